/* hw/pcfg_device.sv */
`timescale 1ns/1ps
module pcfg_device
    import pcfg_pkg::*;
(
    // System
    input wire logic CLK,
    input wire logic RST_B,
    // Feature straps
    input wire logic DECOMP_EN,
    input wire logic SECURE_EN,
    // Link
    pcfg_if.dev LINK,
    // User side
    output logic USER_MODE,
    output logic CFG_ERROR,
    output logic WORD_STB,
    output logic [DATA_W-1:0] WORD_DATA
);
    // Pin synchronisers; data goes through two stages, one fewer than the clock's three.
    logic clk_s1_q, clk_s2_q, clk_s3_q;
    logic req_s1_q, req_s2_q;
    logic [DATA_W-1:0] dat_s1_q, dat_s2_q;
    logic rise, fall;

    pcfg_dstate_t state_q, state_d;
    logic [POR_CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] ratio_q, ratio_d;
    logic [3:0] phase_q, phase_d;
    logic [LEN_W-1:0] wcnt_q, wcnt_d;
    logic [LEN_W-1:0] len_q, len_d;
    logic [DATA_W-1:0] sum_q, sum_d;
    logic sec_q, sec_d;
    logic dec_q, dec_d;
    logic initd_en_q, initd_en_d;
    logic ok_q, ok_d;
    logic last_q, last_d;
    logic stat_oe_q, stat_oe_d;
    logic done_oe_q, done_oe_d;
    logic initd_oe_q, initd_oe_d;
    logic err_q, err_d;
    logic user_q, user_d;
    logic stb_q;
    logic [DATA_W-1:0] wdat_q;
    logic up_load, up_step, up_valid;
    logic [DATA_W-1:0] up_word;

    assign rise = clk_s2_q && !clk_s3_q;
    assign fall = !clk_s2_q && clk_s3_q;

    pcfg_unpack u_unpack (
        .clk(CLK),
        .rst_b(RST_B),
        .load(up_load),
        .step(up_step),
        .secure(sec_q),
        .decomp(dec_q),
        .word_in(dat_s2_q),
        .out_valid(up_valid),
        .word_out(up_word)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ratio_d = ratio_q;
        phase_d = phase_q;
        wcnt_d = wcnt_q;
        len_d = len_q;
        sum_d = sum_q;
        sec_d = sec_q;
        dec_d = dec_q;
        initd_en_d = initd_en_q;
        ok_d = ok_q;
        last_d = last_q;
        stat_oe_d = stat_oe_q;
        done_oe_d = done_oe_q;
        initd_oe_d = initd_oe_q;
        err_d = err_q;
        user_d = user_q;
        up_load = 1'b0;
        up_step = 1'b0;
        unique case (state_q)
            D_POR: begin
                stat_oe_d = 1'b1; // see [RULE_05]
                done_oe_d = 1'b1; // see [RULE_06]
                if (cnt_q == POR_CNT_W'(POR_CYCLES - 1)) begin
                    state_d = D_CLEAR;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            D_CLEAR: begin
                stat_oe_d = 1'b1;
                done_oe_d = 1'b1;
                initd_oe_d = 1'b0;
                initd_en_d = 1'b0;
                user_d = 1'b0;
                err_d = 1'b0;
                if (req_s2_q) begin
                    state_d = D_LOAD;
                    stat_oe_d = 1'b0;
                    sec_d = SECURE_EN;
                    dec_d = DECOMP_EN;
                    ratio_d = pcfg_ratio(DECOMP_EN, SECURE_EN); // see [RULE_01]
                    phase_d = 4'h0;
                    wcnt_d = '0;
                    sum_d = '0;
                    ok_d = 1'b0;
                    last_d = 1'b0;
                end
            end
            D_LOAD: begin
                if (rise) begin
                    phase_d = (phase_q == ratio_q - 4'h1) ? 4'h0 : phase_q + 4'h1;
                    if (phase_q == 4'h0) begin // see [RULE_11]
                        wcnt_d = wcnt_q + 1'b1;
                        if (wcnt_q == '0) begin
                            initd_en_d = dat_s2_q[HDR_INITD_BIT];
                            initd_oe_d = dat_s2_q[HDR_INITD_BIT]; // see [RULE_10]
                            len_d = dat_s2_q[HDR_LEN_LSB +: LEN_W];
                        end else if (wcnt_q <= len_q) begin
                            sum_d = sum_q ^ dat_s2_q;
                            up_load = 1'b1;
                        end else begin
                            ok_d = (dat_s2_q == sum_q);
                            last_d = 1'b1;
                        end
                    end else begin
                        up_step = 1'b1; // see [RULE_02]
                    end
                end else if (last_q && phase_q == 4'h0) begin
                    // Done waits for the last word's surplus edges to pass.
                    if (ok_q) begin
                        state_d = D_DONE;
                        done_oe_d = 1'b0; // see [RULE_08]
                        cnt_d = '0;
                    end else begin
                        state_d = D_ERR;
                        stat_oe_d = 1'b1;
                        err_d = 1'b1;
                    end
                end
            end
            D_DONE: begin
                if (fall) begin
                    if (cnt_q == POR_CNT_W'(DONE_EDGES - 2'h1)) begin
                        state_d = D_INIT; // see [RULE_09]
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            D_INIT: begin
                if (cnt_q == POR_CNT_W'(INIT_CYCLES)) begin
                    state_d = D_USER;
                    initd_oe_d = 1'b0;
                    user_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            D_USER: begin
                user_d = 1'b1;
            end
            D_ERR: begin
                stat_oe_d = 1'b1;
            end
            default: begin
                state_d = D_CLEAR;
            end
        endcase
        // A low request restarts from any state once power-on delay is over.
        if (state_q != D_POR && !req_s2_q) begin // see [RULE_04]
            state_d = D_CLEAR;
            stat_oe_d = 1'b1;
            done_oe_d = 1'b1;
            initd_oe_d = 1'b0;
            user_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            req_s1_q <= 1'b1;
            req_s2_q <= 1'b1;
            dat_s1_q <= 32'h0000_0000;
            dat_s2_q <= 32'h0000_0000;
            state_q <= D_POR;
            cnt_q <= '0;
            ratio_q <= RATIO_PLAIN;
            phase_q <= 4'h0;
            wcnt_q <= '0;
            len_q <= '0;
            sum_q <= 32'h0000_0000;
            sec_q <= 1'b0;
            dec_q <= 1'b0;
            initd_en_q <= 1'b0;
            ok_q <= 1'b0;
            last_q <= 1'b0;
            stat_oe_q <= 1'b1;
            done_oe_q <= 1'b1;
            initd_oe_q <= 1'b0;
            err_q <= 1'b0;
            user_q <= 1'b0;
            stb_q <= 1'b0;
            wdat_q <= 32'h0000_0000;
        end else begin
            clk_s1_q <= LINK.config_clock;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            req_s1_q <= LINK.cfg_req_b;
            req_s2_q <= req_s1_q;
            dat_s1_q <= LINK.cfg_data;
            dat_s2_q <= dat_s1_q;
            state_q <= state_d;
            cnt_q <= cnt_d;
            ratio_q <= ratio_d;
            phase_q <= phase_d;
            wcnt_q <= wcnt_d;
            len_q <= len_d;
            sum_q <= sum_d;
            sec_q <= sec_d;
            dec_q <= dec_d;
            initd_en_q <= initd_en_d;
            ok_q <= ok_d;
            last_q <= last_d;
            stat_oe_q <= stat_oe_d;
            done_oe_q <= done_oe_d;
            initd_oe_q <= initd_oe_d;
            err_q <= err_d;
            user_q <= user_d;
            stb_q <= up_valid;
            wdat_q <= up_valid ? up_word : wdat_q;
        end
    end

    // Open-drain: the driven level is always low, only the enables move.
    assign LINK.stat_b_o = 1'b0;
    assign LINK.stat_b_oe = stat_oe_q;
    assign LINK.done_o = 1'b0;
    assign LINK.done_oe = done_oe_q;
    assign LINK.initd_o = 1'b0;
    assign LINK.initd_oe = initd_oe_q;
    assign USER_MODE = user_q;
    assign CFG_ERROR = err_q;
    assign WORD_STB = stb_q;
    assign WORD_DATA = wdat_q;
endmodule : pcfg_device

/* pkg/pcfg_pkg.sv */
// Overview of operation
// [RULE_01] Host gives r clocks per word: 1, 4, 8.
// [RULE_02] Device spends surplus clocks decrypting and decompressing.
// [RULE_03] Host stops clock r-1 cycles after last word.
// [RULE_04] User mode lines high; request low reconfigures.
// [RULE_05] Status held low through power-on delay.
// [RULE_06] Done stays low until loading succeeds.
// [RULE_07] Paused clock held low; data valid before rise.
// [RULE_08] Full stream sent; done high only without error.
// [RULE_09] Host sends two falling edges after done.
// [RULE_10] Init-done driven low once its option loads.
// [RULE_11] Word captured on every r-th rising edge.
package pcfg_pkg;
    localparam int DATA_W = 32;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_TIME_NS = 20000;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 12;
    localparam logic [3:0] RATIO_PLAIN = 4'h1;
    localparam logic [3:0] RATIO_SECURE = 4'h4;
    localparam logic [3:0] RATIO_DECOMP = 4'h8;
    localparam logic [3:0] HALF_DIV = 4'h4;
    localparam logic [3:0] REQ_LOW_CYCLES = 4'h8;
    localparam logic [3:0] INIT_CYCLES = 4'hF;
    localparam logic [1:0] DONE_EDGES = 2'h2;
    localparam int HDR_INITD_BIT = 0;
    localparam int HDR_LEN_LSB = 16;
    localparam int LEN_W = 16;
    // Key value is arbitrary.
    localparam logic [DATA_W-1:0] KEY_WORD = 32'h5A3C_96E1;

    typedef enum logic [2:0] {
        D_POR = 3'h0,
        D_CLEAR = 3'h1,
        D_LOAD = 3'h2,
        D_DONE = 3'h3,
        D_INIT = 3'h4,
        D_USER = 3'h5,
        D_ERR = 3'h6
    } pcfg_dstate_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_REQ = 3'h1,
        H_WAIT = 3'h2,
        H_CLK = 3'h3,
        H_WAITDONE = 3'h4,
        H_FINAL = 3'h5
    } pcfg_hstate_t;

    function automatic logic [3:0] pcfg_ratio(input logic decomp, input logic secure);
        if (decomp) begin
            return RATIO_DECOMP;
        end
        return secure ? RATIO_SECURE : RATIO_PLAIN;
    endfunction : pcfg_ratio
endpackage : pcfg_pkg

/* pkg/pcfg_if.sv */
`timescale 1ns/1ps
interface pcfg_if;
    logic config_clock;
    logic [31:0] cfg_data;
    logic cfg_req_b;
    logic stat_b_o;
    logic stat_b_oe;
    logic stat_b;
    logic done_o;
    logic done_oe;
    logic done;
    logic initd_o;
    logic initd_oe;
    logic initd;

    // Open-drain lines with pull-ups: released lines read high.
    assign stat_b = stat_b_oe ? stat_b_o : 1'b1;
    assign done = done_oe ? done_o : 1'b1;
    assign initd = initd_oe ? initd_o : 1'b1;

    modport dev (
        input config_clock, cfg_data, cfg_req_b,
        output stat_b_o, stat_b_oe, done_o, done_oe, initd_o, initd_oe
    );
    modport host (
        output config_clock, cfg_data, cfg_req_b,
        input stat_b, done, initd
    );
endinterface : pcfg_if

/* hw/pcfg_unpack.sv */
`timescale 1ns/1ps
module pcfg_unpack
    import pcfg_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic secure,
    input wire logic decomp,
    input wire logic [DATA_W-1:0] word_in,
    // Result
    output logic out_valid,
    output logic [DATA_W-1:0] word_out
);
    logic [DATA_W-1:0] acc_q, acc_d;
    logic [3:0] rounds_q, rounds_d;
    logic pend_q, pend_d;
    logic valid_q, valid_d;

    // One round per surplus edge, so work finishes before the next word arrives.
    always_comb begin
        acc_d = acc_q;
        rounds_d = rounds_q;
        pend_d = pend_q;
        valid_d = 1'b0;
        if (load) begin
            acc_d = word_in;
            rounds_d = pcfg_ratio(decomp, secure) - 4'h1;
            pend_d = 1'b1;
        end else if (pend_q && rounds_q == 4'h0) begin
            pend_d = 1'b0;
            valid_d = 1'b1;
        end else if (step && pend_q) begin
            rounds_d = rounds_q - 4'h1; // see [RULE_02]
            if (secure) begin
                acc_d = {acc_q[0], acc_q[DATA_W-1:1]} ^ KEY_WORD;
            end
            if (decomp) begin
                acc_d = acc_d ^ {acc_d[15:0], acc_d[31:16]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= 32'h0000_0000;
            rounds_q <= 4'h0;
            pend_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            rounds_q <= rounds_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
        end
    end

    assign out_valid = valid_q;
    assign word_out = acc_q;
endmodule : pcfg_unpack

/* hw/pcfg_host.sv */
`timescale 1ns/1ps
module pcfg_host
    import pcfg_pkg::*;
(
    // System
    input wire logic CLK,
    input wire logic RST_B,
    // Command
    input wire logic START,
    input wire logic DECOMP_EN,
    input wire logic SECURE_EN,
    // Word feed
    input wire logic WORD_VALID,
    input wire logic [DATA_W-1:0] WORD_DATA,
    input wire logic WORD_LAST,
    output logic WORD_READY,
    // Status
    output logic BUSY,
    output logic DONE_OK,
    output logic FAIL,
    // Link
    pcfg_if.host LINK
);
    logic stat_s1_q, stat_s2_q;
    logic done_s1_q, done_s2_q;
    pcfg_hstate_t state_q, state_d;
    logic [3:0] div_q, div_d;
    logic [3:0] ratio_q, ratio_d;
    logic [3:0] edge_q, edge_d;
    logic [1:0] falls_q, falls_d;
    logic have_q, have_d;
    logic last_q, last_d;
    logic lclk_q, lclk_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic req_b_q, req_b_d;
    logic ready_q, ready_d;
    logic ok_q, ok_d;
    logic fail_q, fail_d;
    logic fire, half_end;

    assign fire = WORD_VALID && ready_q;
    assign half_end = (div_q == HALF_DIV - 4'h1);

    always_comb begin
        state_d = state_q;
        div_d = div_q;
        ratio_d = ratio_q;
        edge_d = edge_q;
        falls_d = falls_q;
        have_d = have_q;
        last_d = last_q;
        lclk_d = lclk_q;
        data_d = data_q;
        req_b_d = req_b_q;
        ready_d = 1'b0;
        ok_d = ok_q;
        fail_d = fail_q;
        unique case (state_q)
            H_IDLE: begin
                if (START) begin
                    state_d = H_REQ;
                    ratio_d = pcfg_ratio(DECOMP_EN, SECURE_EN); // see [RULE_01]
                    req_b_d = 1'b0; // see [RULE_04]
                    div_d = 4'h0;
                    ok_d = 1'b0;
                    fail_d = 1'b0;
                end
            end
            H_REQ: begin
                div_d = div_q + 4'h1;
                if (div_q == REQ_LOW_CYCLES - 4'h1) begin
                    req_b_d = 1'b1;
                    state_d = H_WAIT;
                end
            end
            H_WAIT: begin
                div_d = 4'h0;
                edge_d = 4'h0;
                have_d = 1'b0;
                last_d = 1'b0;
                lclk_d = 1'b0;
                if (stat_s2_q) begin
                    state_d = H_CLK;
                end
            end
            H_CLK: begin
                if (!lclk_q && edge_q == 4'h0 && !have_q) begin
                    // Clock parks low until the next word is on the bus.
                    div_d = 4'h0; // see [RULE_07]
                    ready_d = !fire && !last_q;
                    if (fire) begin
                        data_d = WORD_DATA;
                        have_d = 1'b1;
                        last_d = WORD_LAST;
                    end
                end else if (half_end) begin
                    div_d = 4'h0;
                    lclk_d = !lclk_q;
                    if (!lclk_q) begin
                        have_d = (edge_q == 4'h0) ? 1'b0 : have_q;
                        edge_d = (edge_q == ratio_q - 4'h1) ? 4'h0 : edge_q + 4'h1;
                    end else if (edge_q == 4'h0 && last_q) begin
                        state_d = H_WAITDONE; // see [RULE_03]
                    end
                end else begin
                    div_d = div_q + 4'h1;
                end
                if (!stat_s2_q) begin
                    state_d = H_IDLE;
                    fail_d = 1'b1;
                end
            end
            H_WAITDONE: begin
                div_d = 4'h0;
                falls_d = 2'h0;
                if (done_s2_q) begin
                    state_d = H_FINAL; // see [RULE_08]
                end else if (!stat_s2_q) begin
                    state_d = H_IDLE;
                    fail_d = 1'b1;
                end
            end
            H_FINAL: begin
                if (half_end) begin
                    div_d = 4'h0;
                    lclk_d = !lclk_q;
                    if (lclk_q) begin
                        falls_d = falls_q + 2'h1;
                        if (falls_q == DONE_EDGES - 2'h1) begin
                            state_d = H_IDLE; // see [RULE_09]
                            ok_d = 1'b1;
                        end
                    end
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
            default: begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_s1_q <= 1'b0;
            stat_s2_q <= 1'b0;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            state_q <= H_IDLE;
            div_q <= 4'h0;
            ratio_q <= RATIO_PLAIN;
            edge_q <= 4'h0;
            falls_q <= 2'h0;
            have_q <= 1'b0;
            last_q <= 1'b0;
            lclk_q <= 1'b0;
            data_q <= 32'h0000_0000;
            req_b_q <= 1'b1;
            ready_q <= 1'b0;
            ok_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            stat_s1_q <= LINK.stat_b;
            stat_s2_q <= stat_s1_q;
            done_s1_q <= LINK.done;
            done_s2_q <= done_s1_q;
            state_q <= state_d;
            div_q <= div_d;
            ratio_q <= ratio_d;
            edge_q <= edge_d;
            falls_q <= falls_d;
            have_q <= have_d;
            last_q <= last_d;
            lclk_q <= lclk_d;
            data_q <= data_d;
            req_b_q <= req_b_d;
            ready_q <= ready_d;
            ok_q <= ok_d;
            fail_q <= fail_d;
        end
    end

    assign LINK.config_clock = lclk_q;
    assign LINK.cfg_data = data_q;
    assign LINK.cfg_req_b = req_b_q;
    assign WORD_READY = ready_q;
    assign BUSY = (state_q != H_IDLE);
    assign DONE_OK = ok_q;
    assign FAIL = fail_q;
endmodule : pcfg_host

/* dv/pcfg_chk_sva.sv */
`timescale 1ns/1ps
module pcfg_chk
    import pcfg_pkg::*;
(
    // System
    input wire logic CLK,
    input wire logic RST_B,
    // Link
    input wire logic config_clock,
    input wire logic [31:0] cfg_data,
    input wire logic cfg_req_b,
    input wire logic stat_b,
    input wire logic done,
    input wire logic initd
);
    // Saturates so a long run never wraps back into the power-on window.
    logic [POR_CNT_W-1:0] por_q;
    logic [POR_CNT_W-1:0] por_d;
    logic por_on;

    assign por_on = por_q < POR_CNT_W'(POR_CYCLES);
    always_comb begin
        por_d = por_on ? por_q + 1'h1 : por_q;
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            por_q <= '0;
        end else begin
            por_q <= por_d;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    property p_por;
        por_on |-> !stat_b && !done;
    endproperty
    a_por: assert property (p_por)
        else $error("status or done high in power-on delay");
    property p_req_abort;
        $fell(cfg_req_b) |-> ##[1:6] (!stat_b && !done);
    endproperty
    a_req_abort: assert property (p_req_abort)
        else $error("request did not restart loading");
    property p_req_len;
        $fell(cfg_req_b) |-> !cfg_req_b [*8];
    endproperty
    a_req_len: assert property (p_req_len)
        else $error("request pulse too short");
    property p_post_falls;
        $rose(done) |-> ##[1:16] $fell(config_clock) ##[1:12] $fell(config_clock);
    endproperty
    a_post_falls: assert property (p_post_falls)
        else $error("two falling edges missing after done");
    property p_initd;
        $rose(initd) && cfg_req_b |-> done;
    endproperty
    a_initd: assert property (p_initd)
        else $error("init-done released before done");
    property p_data_stable;
        !$stable(cfg_data) |-> !config_clock;
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data changed with link clock high");
    property p_high;
        $rose(config_clock) |-> config_clock [*4] ##1 !config_clock;
    endproperty
    a_high: assert property (p_high)
        else $error("link clock high phase wrong");
    property p_low;
        $fell(config_clock) |-> !config_clock [*4];
    endproperty
    a_low: assert property (p_low)
        else $error("link clock low phase short");
    property p_clk_stat;
        $rose(config_clock) |-> stat_b;
    endproperty
    a_clk_stat: assert property (p_clk_stat)
        else $error("link clock while status low");
    property p_done_quiet;
        $rose(done) |-> !config_clock;
    endproperty
    a_done_quiet: assert property (p_done_quiet)
        else $error("done rose while link clock high");
endmodule : pcfg_chk

/* dv/tb_parallel_config_intake.sv */
`timescale 1ns/1ps
module tb_parallel_config_intake
    import pcfg_pkg::*;
;
    logic CLK = 1'h0;
    logic RST_B = 1'h0;
    logic start = 1'h0, dec = 1'h0, sec = 1'h0, wvalid = 1'h0, wlast = 1'h0;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic wready, busy, done_ok, fail, user_mode, cfg_err, wstb, clk_prev;
    logic [DATA_W-1:0] dev_word;
    logic [DATA_W-1:0] stb_q[$];
    int bad_count = 0, cmp_count = 0, rises = 0, ilow = 0, m;

    always #5 CLK = ~CLK;

    pcfg_if pcfg_if_i ();
    pcfg_host pcfg_host_i (.CLK(CLK), .RST_B(RST_B), .START(start), .DECOMP_EN(dec),
        .SECURE_EN(sec), .WORD_VALID(wvalid), .WORD_DATA(wdata), .WORD_LAST(wlast),
        .WORD_READY(wready), .BUSY(busy), .DONE_OK(done_ok), .FAIL(fail),
        .LINK(pcfg_if_i.host));
    pcfg_device pcfg_device_i (.CLK(CLK), .RST_B(RST_B), .DECOMP_EN(dec), .SECURE_EN(sec),
        .LINK(pcfg_if_i.dev), .USER_MODE(user_mode), .CFG_ERROR(cfg_err), .WORD_STB(wstb),
        .WORD_DATA(dev_word));
    pcfg_chk pcfg_chk_i (.CLK(CLK), .RST_B(RST_B), .config_clock(pcfg_if_i.config_clock),
        .cfg_data(pcfg_if_i.cfg_data), .cfg_req_b(pcfg_if_i.cfg_req_b),
        .stat_b(pcfg_if_i.stat_b), .done(pcfg_if_i.done), .initd(pcfg_if_i.initd));

    // Counters only grow, so a load compares differences and never clears them.
    always @(posedge CLK) begin
        clk_prev <= pcfg_if_i.config_clock;
        if (pcfg_if_i.config_clock === 1'h1 && clk_prev === 1'h0) rises <= rises + 1;
        if (pcfg_if_i.initd === 1'h0) ilow <= ilow + 1;
        if (wstb === 1'h1) stb_q.push_back(dev_word);
    end

    task give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task hang(input string msg);
        check(1'h0, msg);
        give_verdict();
    endtask : hang

    function automatic int ratio(input logic d, input logic s);
        return d ? 8 : (s ? 4 : 1);
    endfunction : ratio

    function automatic logic [31:0] proc(input logic [31:0] w, input logic d, input logic s);
        logic [31:0] a;
        a = w;
        for (int i = 1; i < ratio(d, s); i++) begin
            if (s) a = {a[0], a[31:1]} ^ KEY_WORD;
            if (d) a = a ^ {a[15:0], a[31:16]};
        end
        return a;
    endfunction : proc

    // Valid is held across words; it drops only after the checksum is taken.
    task send_word(input logic [31:0] w, input logic last);
        int n;
        wvalid <= 1'h1;
        wdata <= w;
        wlast <= last;
        for (n = 0; n < 20000; n++) begin
            @(negedge CLK);
            if (wready === 1'h1) break;
        end
        if (n == 20000) hang("word never taken");
        @(posedge CLK);
    endtask : send_word

    task load(input logic d, input logic s, input logic bad, input logic ie);
        logic [31:0] w[4];
        int r0, l0, n, k;
        w[0] = {16'h0002, 15'h0000, ie};
        w[1] = 32'h1357_9BDF ^ {29'h0, d, s, ie};
        w[2] = 32'h2468_ACE0;
        w[3] = w[1] ^ w[2] ^ {31'h0, bad};
        stb_q = {};
        @(posedge CLK);
        start <= 1'h1;
        dec <= d;
        sec <= s;
        @(posedge CLK);
        start <= 1'h0;
        r0 = rises;
        l0 = ilow;
        for (k = 0; k < 4; k++) send_word(w[k], k == 3);
        wvalid <= 1'h0;
        wlast <= 1'h0;
        for (n = 0; n < 20000; n++) begin
            @(negedge CLK);
            if (busy === 1'h0) break;
        end
        if (n == 20000) hang("host stayed busy");
        if (bad) begin
            check(fail === 1'h1 && cfg_err === 1'h1, "bad stream not flagged");
            check(pcfg_if_i.done === 1'h0 && user_mode === 1'h0, "done after bad");
            return;
        end
        check(rises - r0 == 4 * ratio(d, s) + 2, "link clock count");
        check(done_ok === 1'h1 && fail === 1'h0 && cfg_err === 1'h0, "load result");
        for (n = 0; n < 200; n++) begin
            @(negedge CLK);
            if (user_mode === 1'h1) break;
        end
        check(user_mode === 1'h1 && pcfg_if_i.stat_b === 1'h1, "no user mode");
        check(pcfg_if_i.done === 1'h1 && pcfg_if_i.cfg_req_b === 1'h1, "user lines");
        check(pcfg_if_i.initd === 1'h1 && (ilow != l0) == ie, "init-done");
        for (k = 0; k < stb_q.size(); k++) begin
            if (stb_q[k] === proc(w[1], d, s)) break;
        end
        check(k + 1 < stb_q.size(), "first word missing");
        if (k + 1 < stb_q.size()) check(stb_q[k + 1] === proc(w[2], d, s), "word");
    endtask : load

    initial begin
        repeat (20) @(posedge CLK);
        RST_B <= 1'h1;
        repeat (100) @(posedge CLK);
        check(pcfg_if_i.stat_b === 1'h0 && pcfg_if_i.done === 1'h0, "power-on");
        for (m = 0; m < 4; m++) load(logic'(m >> 1), logic'(m & 1), 1'h0, logic'(m & 1));
        load(1'h0, 1'h0, 1'h1, 1'h0);
        load(1'h0, 1'h0, 1'h0, 1'h1);
        give_verdict();
    end
endmodule : tb_parallel_config_intake
